/* File: hdl/fifo_crc_pkg.sv */
package fifo_crc_pkg;

  // ----------------------------------------
  // Buffer geometry
  // ----------------------------------------
  localparam int BYTE_W    = 8;
  localparam int BUF_DEPTH = 64;
  localparam int PTR_W     = $clog2(BUF_DEPTH);
  localparam int CNT_W     = PTR_W + 1;
  localparam int THR_W     = 6;

  localparam logic [CNT_W-1:0]  CNT_EMPTY = 7'h00;
  localparam logic [CNT_W-1:0]  CNT_FULL  = 7'h40;
  localparam logic [PTR_W-1:0]  PTR_ZERO  = 6'h00;
  localparam logic [PTR_W-1:0]  PTR_ONE   = 6'h01;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 7'h01;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------
  // Checksum unit
  // ----------------------------------------
  localparam int CRC_W     = 16;
  localparam int PRESET_SW = 2;

  localparam logic [CRC_W-1:0] CRC_POLY      = 16'h1021;
  localparam logic [CRC_W-1:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [CRC_W-1:0] CRC_PRESET_0  = 16'h0000;
  localparam logic [CRC_W-1:0] CRC_PRESET_1  = 16'h6363;
  localparam logic [CRC_W-1:0] CRC_PRESET_2  = 16'ha671;
  localparam logic [CRC_W-1:0] CRC_PRESET_3  = 16'hffff;
  localparam logic [CRC_W-1:0] CRC_RESET     = 16'h0000;

  localparam logic [PRESET_SW-1:0] PSEL_0 = 2'h0;
  localparam logic [PRESET_SW-1:0] PSEL_1 = 2'h1;
  localparam logic [PRESET_SW-1:0] PSEL_2 = 2'h2;

  typedef enum logic [0:0] {
    CRC_IDLE,
    CRC_RUN
  } crc_state_t;

endpackage

/* File: hdl/byte_stream_if.sv */
`timescale 1ns/1ps
interface byte_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // byte_stream_if

/* File: hdl/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo
  import fifo_crc_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = BUF_DEPTH
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Control
  input  wire logic           flush,
  // Streams
  byte_stream_if.snk          wr,
  byte_stream_if.src          rd,
  // Status
  output      logic [CNT_W-1:0] count
);

  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  // Depth must be a power of two: pointers wrap by overflow
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic             push;
  logic             pop;

  assign wr.ready = (count_q != CNT_FULL);
  assign rd.valid = (count_q != CNT_EMPTY);
  assign rd.data  = mem_q[rd_ptr_q];
  assign push     = wr.valid & wr.ready & ~flush;
  assign pop      = rd.valid & rd.ready & ~flush;
  assign count    = count_q;

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && (wr_ptr_q == PTR_W'(i))) begin
        mem_q[i] <= wr.data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= PTR_ZERO;
      rd_ptr_q <= PTR_ZERO;
    end else if (flush) begin
      wr_ptr_q <= PTR_ZERO;
      rd_ptr_q <= PTR_ZERO;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + PTR_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= CNT_EMPTY;
    end else if (flush) begin
      count_q <= CNT_EMPTY;
    end else if (push && !pop) begin
      count_q <= count_q + CNT_ONE;
    end else if (pop && !push) begin
      count_q <= count_q - CNT_ONE;
    end
  end

endmodule // byte_fifo

/* File: hdl/crc16_unit.sv */
`timescale 1ns/1ps
module crc16_unit
  import fifo_crc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Control
  input  wire logic                 load,
  input  wire logic [PRESET_SW-1:0] preset_sel,
  input  wire logic                 msb_first,
  // Data
  input  wire logic                 byte_valid,
  input  wire logic [BYTE_W-1:0]    byte_data,
  // Result
  output      logic [CRC_W-1:0]     crc_q
);

  // ----------------------------------------
  // Byte step
  // ----------------------------------------
  // Fixed polynomial step
  function automatic logic [CRC_W-1:0] crc_step(
    input logic [CRC_W-1:0]  crc,
    input logic [BYTE_W-1:0] din,
    input logic              msb
  );
    logic [CRC_W-1:0] c;
    logic             fb;
    c = crc;
    for (int b = 0; b < BYTE_W; b++) begin
      if (msb) begin
        fb = c[CRC_W-1] ^ din[BYTE_W-1-b];
        c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_RESET);
      end else begin
        fb = c[0] ^ din[b];
        c  = {1'b0, c[CRC_W-1:1]} ^ (fb ? CRC_POLY_REFL : CRC_RESET);
      end
    end
    return c;
  endfunction

  logic [CRC_W-1:0] preset;

  always_comb begin
    if (preset_sel == PSEL_0) begin
      preset = CRC_PRESET_0;
    end else if (preset_sel == PSEL_1) begin
      preset = CRC_PRESET_1;
    end else if (preset_sel == PSEL_2) begin
      preset = CRC_PRESET_2;
    end else begin
      preset = CRC_PRESET_3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= CRC_RESET;
    end else if (load) begin
      crc_q <= preset;
    end else if (byte_valid) begin
      crc_q <= crc_step(crc_q, byte_data, msb_first);
    end
  end

endmodule // crc16_unit

/* File: hdl/shared_fifo_with_crc_unit.sv */
// Contract
// - One buffer of 64 bytes shared by host and protocol engine.
// - A host write stores one byte and advances the write pointer.
// - A host read returns the byte at read pointer, then advances it.
// - Stored byte count is readable as a 7-bit fill count.
// - Flush resets pointers, zeroes count and clears overflow unless a write is refused in the same cycle.
// - Overflow stays set until flush; nothing else clears it.
// - Near-full is set when 64 minus count is at most threshold.
// - Near-empty is set when count is at most threshold.
// - Enabled near-empty rising edge raises the interrupt pin.
// - Enabled near-full rising edge raises the interrupt pin.
// - Checksum preset chosen by 2-bit select: 0000, 6363, a671, ffff.
// - 16-bit checksum with fixed polynomial x16+x12+x5+1.
// - Checksum result read as separate upper and lower bytes.
// - Bit order select set takes bytes msb first, else lsb first.
// - After consuming all buffered bytes, set ready and done flag.
`timescale 1ns/1ps
module shared_fifo_with_crc_unit
  import fifo_crc_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,

  // Host data port
  input  wire logic                 host_wr_en,
  input  wire logic [BYTE_W-1:0]    host_wr_data,
  input  wire logic                 host_rd_en,
  output      logic [BYTE_W-1:0]    host_rd_data,
  output      logic                 host_rd_valid,

  // Protocol engine port
  input  wire logic                 sm_wr_en,
  input  wire logic [BYTE_W-1:0]    sm_wr_data,
  input  wire logic                 sm_rd_en,
  output      logic [BYTE_W-1:0]    sm_rd_data,
  output      logic                 sm_rd_valid,

  // Buffer control
  input  wire logic                 flush_request,
  input  wire logic [THR_W-1:0]     fill_threshold,

  // Buffer status
  output      logic [CNT_W-1:0]     stored_byte_count,
  output      logic                 buf_not_full,
  output      logic                 overflow_flag,
  output      logic                 near_full_flag,
  output      logic                 near_empty_flag,

  // Alert interrupts
  input  wire logic                 near_full_irq_enable,
  input  wire logic                 near_empty_irq_enable,
  input  wire logic                 alert_irq_clear,
  output      logic                 near_full_irq_pend,
  output      logic                 near_empty_irq_pend,
  output      logic                 irq_out,

  // Checksum unit
  input  wire logic                 checksum_start,
  input  wire logic [PRESET_SW-1:0] checksum_preset_select,
  input  wire logic                 bit_order_select,
  input  wire logic                 checksum_done_clear,
  output      logic [BYTE_W-1:0]    checksum_result_hi,
  output      logic [BYTE_W-1:0]    checksum_result_lo,
  output      logic                 checksum_ready,
  output      logic                 checksum_done_flag
);

  // ----------------------------------------
  // Buffer instance
  // ----------------------------------------
  byte_stream_if #(.W(BYTE_W)) wr_s ();
  byte_stream_if #(.W(BYTE_W)) rd_s ();

  logic [CNT_W-1:0] fill_cnt;

  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .clk   (core_clk),
    .rst_n (rst_n),
    .flush (flush_request),
    .wr    (wr_s.snk),
    .rd    (rd_s.src),
    .count (fill_cnt)
  );

  // ----------------------------------------
  // Write arbitration
  // ----------------------------------------
  logic wr_any;
  logic wr_refused;

  // Engine byte is lost when both sides write in one cycle
  // Host wins a same-cycle clash
  always_comb begin
    wr_s.valid = 1'b0;
    wr_s.data  = BYTE_ZERO;
    if (host_wr_en) begin
      wr_s.valid = ~flush_request;
      wr_s.data  = host_wr_data;
    end else if (sm_wr_en) begin
      wr_s.valid = ~flush_request;
      wr_s.data  = sm_wr_data;
    end
  end

  assign wr_any     = host_wr_en | sm_wr_en;
  assign wr_refused = wr_any & ~wr_s.ready;

  // ----------------------------------------
  // Read arbitration
  // ----------------------------------------
  crc_state_t crc_state_q;
  logic       crc_take;
  logic       host_take;
  logic       sm_take;

  // Host first, engine next; checksum only drains in idle cycles
  assign host_take  = host_rd_en & rd_s.valid & ~flush_request;
  assign sm_take    = sm_rd_en & ~host_rd_en & rd_s.valid & ~flush_request;
  assign crc_take   = (crc_state_q == CRC_RUN) & ~host_rd_en & ~sm_rd_en
                      & rd_s.valid & ~flush_request;
  assign rd_s.ready = host_rd_en | sm_rd_en | (crc_state_q == CRC_RUN);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rd_data  <= BYTE_ZERO;
      host_rd_valid <= 1'b0;
    end else begin
      host_rd_valid <= host_take;
      host_rd_data  <= host_take ? rd_s.data : BYTE_ZERO;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sm_rd_data  <= BYTE_ZERO;
      sm_rd_valid <= 1'b0;
    end else begin
      sm_rd_valid <= sm_take;
      sm_rd_data  <= sm_take ? rd_s.data : BYTE_ZERO;
    end
  end

  // ----------------------------------------
  // Fill status
  // ----------------------------------------
  logic [CNT_W-1:0] thr_ext;
  logic [CNT_W-1:0] free_cnt;
  logic             near_full_d;
  logic             near_empty_d;

  assign thr_ext      = {1'b0, fill_threshold};
  assign free_cnt     = CNT_FULL - fill_cnt;
  assign near_full_d  = (free_cnt <= thr_ext);
  assign near_empty_d = (fill_cnt <= thr_ext);

  // Registered copies keep outputs glitch free, one cycle behind
  // Fill count output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stored_byte_count <= CNT_EMPTY;
    end else begin
      stored_byte_count <= fill_cnt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_not_full <= 1'b1;
    end else begin
      buf_not_full <= wr_s.ready;
    end
  end

  // Reset value follows an empty buffer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      near_full_flag <= 1'b0;
    end else begin
      near_full_flag <= near_full_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      near_empty_flag <= 1'b1;
    end else begin
      near_empty_flag <= near_empty_d;
    end
  end

  // ----------------------------------------
  // Overflow
  // ----------------------------------------
  // A refused write in a flush cycle still marks the loss
  // Only flush clears; set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (wr_refused) begin
      overflow_flag <= 1'b1;
    end else if (flush_request) begin
      overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Alert interrupts
  // ----------------------------------------
  logic nf_rise;
  logic ne_rise;

  assign nf_rise = near_full_d & ~near_full_flag;
  assign ne_rise = near_empty_d & ~near_empty_flag;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      near_full_irq_pend <= 1'b0;
    end else if (nf_rise) begin
      near_full_irq_pend <= 1'b1;
    end else if (alert_irq_clear) begin
      near_full_irq_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      near_empty_irq_pend <= 1'b0;
    end else if (ne_rise) begin
      near_empty_irq_pend <= 1'b1;
    end else if (alert_irq_clear) begin
      near_empty_irq_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (near_full_irq_pend & near_full_irq_enable)
               | (near_empty_irq_pend & near_empty_irq_enable);
    end
  end

  // ----------------------------------------
  // Checksum sequencing
  // ----------------------------------------
  logic [CRC_W-1:0] crc_val;
  logic             crc_load;
  logic             crc_finish;

  // A start while running is ignored
  assign crc_load   = (crc_state_q == CRC_IDLE) & checksum_start;
  assign crc_finish = (crc_state_q == CRC_RUN) & ~rd_s.valid;

  crc16_unit u_crc (
    .clk        (core_clk),
    .rst_n      (rst_n),
    .load       (crc_load),
    .preset_sel (checksum_preset_select),
    .msb_first  (bit_order_select),
    .byte_valid (crc_take),
    .byte_data  (rd_s.data),
    .crc_q      (crc_val)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_state_q <= CRC_IDLE;
    end else begin
      case (crc_state_q)
        CRC_IDLE: begin
          if (checksum_start) begin
            crc_state_q <= CRC_RUN;
          end
        end
        CRC_RUN: begin
          if (crc_finish) begin
            crc_state_q <= CRC_IDLE;
          end
        end
        default: begin
          crc_state_q <= CRC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      checksum_ready <= 1'b0;
    end else if (crc_finish) begin
      checksum_ready <= 1'b1;
    end else if (crc_load) begin
      checksum_ready <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      checksum_done_flag <= 1'b0;
    end else if (crc_finish) begin
      checksum_done_flag <= 1'b1;
    end else if (checksum_done_clear) begin
      checksum_done_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checksum result
  // ----------------------------------------
  // Own flops keep the result pins straight off a register
  // Split result bytes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      checksum_result_hi <= BYTE_ZERO;
      checksum_result_lo <= BYTE_ZERO;
    end else begin
      checksum_result_hi <= crc_val[CRC_W-1:BYTE_W];
      checksum_result_lo <= crc_val[BYTE_W-1:0];
    end
  end

endmodule // shared_fifo_with_crc_unit

/* File: dv/shared_fifo_with_crc_unit_sva.sv */
`timescale 1ns/1ps
module shared_fifo_with_crc_unit_sva
  import fifo_crc_pkg::*;
(
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             rst_n,
  // Buffer side
  input wire logic             host_wr_en,
  input wire logic             host_rd_en,
  input wire logic             host_rd_valid,
  input wire logic             sm_wr_en,
  input wire logic             sm_rd_en,
  input wire logic             sm_rd_valid,
  input wire logic             flush_request,
  input wire logic [THR_W-1:0] fill_threshold,
  input wire logic [CNT_W-1:0] stored_byte_count,
  input wire logic             overflow_flag,
  input wire logic             near_full_flag,
  input wire logic             near_empty_flag,
  // Alerts and checksum
  input wire logic             near_full_irq_enable,
  input wire logic             near_empty_irq_enable,
  input wire logic             near_full_irq_pend,
  input wire logic             near_empty_irq_pend,
  input wire logic             irq_out,
  input wire logic             checksum_ready,
  input wire logic             checksum_done_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_CNT_MAX: assert property (stored_byte_count <= CNT_FULL)
    else $error("fill count above depth");
  AST_CNT_STEP: assert property (!$past(flush_request, 2) |->
    (stored_byte_count == $past(stored_byte_count) ||
     stored_byte_count == $past(stored_byte_count) + CNT_ONE ||
     stored_byte_count == $past(stored_byte_count) - CNT_ONE))
    else $error("fill count jumped");
  AST_FLUSH_CNT: assert property (flush_request |-> ##2 stored_byte_count == CNT_EMPTY)
    else $error("flush left bytes counted");
  AST_FLUSH_OVF: assert property (flush_request && !host_wr_en && !sm_wr_en |=> !overflow_flag)
    else $error("flush kept overflow");
  AST_OVF_STICKY: assert property (overflow_flag && !flush_request |=> overflow_flag)
    else $error("overflow dropped without flush");
  AST_OVF_CAUSE: assert property ($rose(overflow_flag) |-> $past(host_wr_en || sm_wr_en))
    else $error("overflow without write");
  // Threshold sampled one edge back, so only judged while steady
  AST_NEAR_FULL: assert property ($stable(fill_threshold) |->
    near_full_flag == ((CNT_FULL - stored_byte_count) <= {1'b0, fill_threshold}))
    else $error("near full wrong");
  AST_NEAR_EMPTY: assert property ($stable(fill_threshold) |->
    near_empty_flag == (stored_byte_count <= {1'b0, fill_threshold}))
    else $error("near empty wrong");
  AST_HOST_RD: assert property (host_rd_valid |-> $past(host_rd_en))
    else $error("host byte without read");
  AST_SM_RD: assert property (sm_rd_valid |-> $past(sm_rd_en && !host_rd_en))
    else $error("engine byte without read");
  AST_NE_PEND: assert property ($rose(near_empty_flag) |-> near_empty_irq_pend)
    else $error("near empty edge not latched");
  AST_NE_IRQ: assert property (near_empty_irq_pend && near_empty_irq_enable |=> irq_out)
    else $error("near empty irq missing");
  AST_NF_PEND: assert property ($rose(near_full_flag) |-> near_full_irq_pend)
    else $error("near full edge not latched");
  AST_NF_IRQ: assert property (near_full_irq_pend && near_full_irq_enable |=> irq_out)
    else $error("near full irq missing");
  AST_DONE: assert property ($rose(checksum_done_flag) |-> checksum_ready)
    else $error("done without ready");
endmodule // shared_fifo_with_crc_unit_sva

bind shared_fifo_with_crc_unit shared_fifo_with_crc_unit_sva u_shared_fifo_with_crc_unit_sva (.*);

/* File: dv/engine_model.sv */
`timescale 1ns/1ps
module engine_model
  import fifo_crc_pkg::*;
(
  // Clock
  input  wire logic              core_clk,
  // Bench commands
  input  wire logic [CNT_W-1:0]  send_len,
  input  wire logic [BYTE_W-1:0] send_base,
  input  wire logic              send_go,
  input  wire logic              drain_go,
  // Engine port
  output      logic              sm_wr_en,
  output      logic [BYTE_W-1:0] sm_wr_data,
  output      logic              sm_rd_en,
  input  wire logic [BYTE_W-1:0] sm_rd_data,
  input  wire logic              sm_rd_valid,
  // Results
  output      int                got_count,
  output      logic [BYTE_W-1:0] got_last
);
  initial begin
    sm_wr_en = 1'b0;
    sm_wr_data = 8'h00;
    forever begin
      @(posedge core_clk);
      if (send_go) begin
        for (int i = 0; i < send_len; i++) begin
          @(negedge core_clk);
          sm_wr_en = 1'b1;
          sm_wr_data = send_base + 8'(i);
        end
        @(negedge core_clk);
        sm_wr_en = 1'b0;
        // Released data shows garbage, not the last byte
        sm_wr_data = ~sm_wr_data;
      end
    end
  end

  // Read enable moves on the falling edge like all other stimulus
  always @(negedge core_clk) begin
    sm_rd_en <= drain_go;
  end

  always @(posedge core_clk) begin
    if (sm_rd_valid === 1'b1) begin
      got_count <= got_count + 1;
      got_last <= sm_rd_data;
    end
  end
endmodule // engine_model

/* File: dv/shared_fifo_with_crc_unit_test.sv */
`timescale 1ns/1ps
module shared_fifo_with_crc_unit_test;
  import fifo_crc_pkg::*;
  logic core_clk = 1'b0, rst_n, host_wr_en, host_rd_en, flush_request, checksum_start;
  logic near_full_irq_enable, near_empty_irq_enable, alert_irq_clear, bit_order_select;
  logic checksum_done_clear, sm_wr_en, sm_rd_en, send_go, drain_go, host_rd_valid;
  logic sm_rd_valid, buf_not_full, overflow_flag, near_full_flag, near_empty_flag;
  logic near_full_irq_pend, near_empty_irq_pend, irq_out, checksum_ready, checksum_done_flag;
  logic [7:0] host_wr_data, host_rd_data, sm_wr_data, sm_rd_data, send_base, got_last;
  logic [7:0] checksum_result_hi, checksum_result_lo;
  logic [6:0] stored_byte_count, send_len;
  logic [5:0] fill_threshold;
  logic [1:0] checksum_preset_select;
  int         got_count, bad_count = 0, checks = 0;

  shared_fifo_with_crc_unit u_shared_fifo_with_crc_unit (.*);
  engine_model u_engine_model (.*);

  always #4 core_clk = ~core_clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic idle();
    @(negedge core_clk);
    {host_wr_en, host_rd_en, flush_request, checksum_start} = 4'h0;
    {alert_irq_clear, checksum_done_clear, send_go} = 3'h0;
  endtask

  task automatic settle();
    repeat (3) idle();
  endtask

  task automatic put(input logic [7:0] b);
    @(negedge core_clk);
    host_wr_en = 1'b1;
    host_wr_data = b;
  endtask

  task automatic get(input logic [7:0] exp, input logic vld);
    @(negedge core_clk);
    host_wr_en = 1'b0;
    host_rd_en = 1'b1;
    @(negedge core_clk);
    host_rd_en = 1'b0;
    check(host_rd_valid, vld, "read valid");
    if (vld) check(host_rd_data, exp, "read byte");
    else check(host_rd_data, 8'h00, "idle byte");
  endtask

  // Reference checksum, kept apart from the design on purpose
  function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [23:0] w,
                                          input logic msb);
    logic [7:0] b;
    logic fb;
    for (int k = 0; k < 3; k++) begin
      b = w[23-8*k -: 8];
      for (int j = 0; j < 8; j++) begin
        fb = msb ? c[15] ^ b[7-j] : c[0] ^ b[j];
        c = msb ? {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000)
                : {1'b0, c[15:1]} ^ (fb ? 16'h8408 : 16'h0000);
      end
    end
    return c;
  endfunction

  task automatic t_fill();
    near_full_irq_enable = 1'b1;
    for (int i = 0; i < 59; i++) put(8'(i));
    settle();
    check(near_full_flag, 1'b0, "near full at 59");
    for (int i = 59; i < 64; i++) put(8'(i));
    settle();
    check(stored_byte_count, 7'h40, "full count");
    check(buf_not_full, 1'b0, "full flag");
    check({near_full_flag, near_empty_flag}, 2'b10, "flags full");
    check({near_full_irq_pend, irq_out}, 2'b11, "near full irq");
    put(8'hee);
    settle();
    check({overflow_flag, stored_byte_count}, 8'hc0, "overflow");
    near_empty_irq_enable = 1'b1;
    near_full_irq_enable = 1'b0;
    for (int i = 0; i < 59; i++) get(8'(i), 1'b1);
    settle();
    check(near_empty_flag, 1'b0, "near empty at 5");
    for (int i = 59; i < 64; i++) get(8'(i), 1'b1);
    get(8'h00, 1'b0);
    settle();
    check({overflow_flag, stored_byte_count}, 8'h80, "sticky overflow");
    check({near_empty_irq_pend, irq_out}, 2'b11, "near empty irq");
    near_empty_irq_enable = 1'b0;
    @(negedge core_clk);
    alert_irq_clear = 1'b1;
    settle();
    check({near_full_irq_pend, near_empty_irq_pend, irq_out}, 3'h0, "irq cleared");
    $display("fill test done");
  endtask

  task automatic t_flush();
    for (int i = 0; i < 3; i++) put(8'h30);
    @(negedge core_clk);
    host_wr_en = 1'b0;
    flush_request = 1'b1;
    settle();
    check({overflow_flag, stored_byte_count}, 8'h00, "flush");
    check(buf_not_full, 1'b1, "free after flush");
    put(8'h5a);
    get(8'h5a, 1'b1);
    settle();
    $display("flush test done");
  endtask

  task automatic t_crc();
    logic [15:0] pre [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
    logic [23:0] w;
    for (int s = 0; s < 8; s++) begin
      w = {8'h12, 8'h34, 8'(s * 37)};
      checksum_preset_select = 2'(s >> 1);
      bit_order_select = s[0];
      for (int k = 0; k < 3; k++) put(w[23-8*k -: 8]);
      @(negedge core_clk);
      host_wr_en = 1'b0;
      checksum_start = 1'b1;
      idle();
      for (int n = 0; n < 20 && checksum_ready !== 1'b1; n++) idle();
      check({checksum_ready, checksum_done_flag}, 2'b11, "checksum done");
      check({checksum_result_hi, checksum_result_lo},
            crc_ref(pre[s >> 1], w, s[0]), "checksum value");
      checksum_done_clear = 1'b1;
      settle();
      check({checksum_done_flag, stored_byte_count}, 8'h00, "drained");
    end
    $display("checksum test done");
  endtask

  task automatic t_engine();
    send_len = 7'h05;
    send_base = 8'h50;
    @(negedge core_clk);
    send_go = 1'b1;
    repeat (8) idle();
    for (int i = 0; i < 5; i++) get(8'h50 + 8'(i), 1'b1);
    for (int i = 0; i < 3; i++) put(8'ha0 + 8'(i));
    idle();
    drain_go = 1'b1;
    repeat (6) idle();
    drain_go = 1'b0;
    settle();
    check({16'(got_count)}, 16'h0003, "engine count");
    check(got_last, 8'ha2, "engine last byte");
    $display("engine test done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    {host_wr_en, host_rd_en, flush_request, checksum_start, alert_irq_clear} = 5'h0;
    {checksum_done_clear, send_go, drain_go, bit_order_select} = 4'h0;
    {near_full_irq_enable, near_empty_irq_enable} = 2'h0;
    {host_wr_data, send_base, send_len, checksum_preset_select} = 25'h0;
    fill_threshold = 6'h04;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    settle();
    check({overflow_flag, stored_byte_count}, 8'h00, "reset state");
    check(near_empty_flag, 1'b1, "reset near empty");
    check(buf_not_full, 1'b1, "reset not full");
    t_fill();
    t_flush();
    t_crc();
    t_engine();
    finish_test();
  end
endmodule // shared_fifo_with_crc_unit_test
